/* rtl/dpram_port_defines.vh */
// timing counts, addresses and codes for the dual-port ram port controller
`ifndef DPRAM_PORT_DEFINES_VH
`define DPRAM_PORT_DEFINES_VH
`define ADDR_W          15
`define DATA_W          16
`define MAIL_LEFT_ADDR  15'h7FFE
`define MAIL_RIGHT_ADDR 15'h7FFF
`define SEM_COUNT       8
`define SEM_REQUEST     16'h0000
`define SEM_RELEASE     16'h0001
`define SETUP_NS        40
`define STROBE_NS       40
`define HOLD_NS         16
`define CLK_MHZ         125
`define SETUP_CYC       ((`SETUP_NS * `CLK_MHZ + 999) / 1000)
`define STROBE_CYC      ((`STROBE_NS * `CLK_MHZ + 999) / 1000)
`define HOLD_CYC        ((`HOLD_NS * `CLK_MHZ + 999) / 1000)
`define OP_READ         2'h0
`define OP_WRITE        2'h1
`define OP_SEM_TAKE     2'h2
`define OP_SEM_FREE     2'h3
`endif

/* rtl/pin_sync.v */
// three-stage synchroniser for one pin, change taken when stages two and three agree
`timescale 1ns/1ps
module pin_sync #(
  parameter RESET_VAL = 1'b1
) (
  input  wire core_clk,
  input  wire rst,
  input  wire pinIn,
  output reg  pinOut
);
  reg stage1;
  reg stage2;
  reg stage3;
  always @(posedge core_clk or posedge rst) begin
    if (rst) begin
      stage1 <= RESET_VAL;
      stage2 <= RESET_VAL;
      stage3 <= RESET_VAL;
      pinOut <= RESET_VAL;
    end else begin
      stage1 <= pinIn;
      stage2 <= stage1;
      stage3 <= stage2;
      if (stage2 == stage3) begin
        pinOut <= stage3;
      end
    end
  end
endmodule

/* rtl/dpram_port_ctrl.v */
// host-side controller for one port of the dual-port ram: array, mailbox, semaphore
`timescale 1ns/1ps
`include "dpram_port_defines.vh"
module dpram_port_ctrl #(
  parameter IS_LEFT    = 1,
  parameter SETUP_CYC  = `SETUP_CYC,
  parameter STROBE_CYC = `STROBE_CYC,
  parameter HOLD_CYC   = `HOLD_CYC
) (
  input  wire                core_clk,
  input  wire                rst,
  input  wire                reqValid,
  output wire                reqReady,
  input  wire [1:0]          reqOp,
  input  wire [`ADDR_W-1:0]  reqAddr,
  input  wire [`DATA_W-1:0]  reqData,
  output reg                 rspValid,
  output reg  [`DATA_W-1:0]  rspData,
  output reg                 rspBusy,
  output reg                 semOwned,
  output reg                 mailboxPending,
  output reg  [`ADDR_W-1:0]  addrPin,
  output reg                 arraySelectN,
  output reg                 tokenSpaceSelectN,
  output reg                 readWriteN,
  output reg                 outputDriveN,
  input  wire [`DATA_W-1:0]  dataPinIn,
  output reg  [`DATA_W-1:0]  dataPinOut,
  output reg                 dataPinOe,
  input  wire                busyPinN,
  input  wire                mailboxFlagPinN
);
  localparam ST_IDLE   = 3'h0;
  localparam ST_SETUP  = 3'h1;
  localparam ST_STROBE = 3'h2;
  localparam ST_HOLD   = 3'h3;
  localparam ST_VERIFY = 3'h4;
  localparam CNT_W     = 8;
  localparam [`ADDR_W-1:0] OWN_MAIL = IS_LEFT ? `MAIL_LEFT_ADDR : `MAIL_RIGHT_ADDR;

  reg  [2:0]         state;
  reg  [CNT_W-1:0]   count;
  reg  [1:0]         op;
  reg                verifyPhase;
  reg                busySeen;
  wire               busySync;
  wire               flagSync;
  wire               isWrite;

  // busy pin is only ever an input here: the array is wired with a single master
  pin_sync #(.RESET_VAL(1'b1)) syncBusy (
    .core_clk (core_clk),
    .rst      (rst),
    .pinIn    (busyPinN),
    .pinOut   (busySync)
  );
  pin_sync #(.RESET_VAL(1'b1)) syncFlag (
    .core_clk (core_clk),
    .rst      (rst),
    .pinIn    (mailboxFlagPinN),
    .pinOut   (flagSync)
  );

  assign reqReady = (state == ST_IDLE);
  assign isWrite  = (op != `OP_READ) && !verifyPhase;

  always @(posedge core_clk or posedge rst) begin
    if (rst) begin
      state             <= ST_IDLE;
      count             <= 8'h00;
      op                <= 2'h0;
      verifyPhase       <= 1'b0;
      busySeen          <= 1'b0;
      rspValid          <= 1'b0;
      rspData           <= 16'h0000;
      rspBusy           <= 1'b0;
      semOwned          <= 1'b0;
      mailboxPending    <= 1'b0;
      addrPin           <= 15'h0000;
      arraySelectN      <= 1'b1;
      tokenSpaceSelectN <= 1'b1;
      readWriteN        <= 1'b1;
      outputDriveN      <= 1'b1;
      dataPinOut        <= 16'h0000;
      dataPinOe         <= 1'b0;
    end else begin
      rspValid       <= 1'b0;
      mailboxPending <= !flagSync;
      case (state)
        ST_IDLE: begin
          // both selects high keeps the device port in standby between accesses
          arraySelectN      <= 1'b1;
          tokenSpaceSelectN <= 1'b1;
          readWriteN        <= 1'b1;
          outputDriveN      <= 1'b1;
          dataPinOe         <= 1'b0;
          if (reqValid) begin
            op          <= reqOp;
            verifyPhase <= 1'b0;
            busySeen    <= 1'b0;
            count       <= 8'h00;
            state       <= ST_SETUP;
            if (reqOp[1]) begin
              // only A0-A2 matter to the token space; data bit zero carries the value
              addrPin           <= {12'h000, reqAddr[2:0]};
              tokenSpaceSelectN <= 1'b0;
              dataPinOut        <= (reqOp == `OP_SEM_TAKE) ? `SEM_REQUEST : `SEM_RELEASE;
            end else begin
              addrPin      <= reqAddr;
              arraySelectN <= 1'b0;
              dataPinOut   <= reqData;
            end
          end
        end
        ST_SETUP: begin
          // address and select held steady so a master's busy settles before the strobe
          count <= count + 8'h01;
          if (count == SETUP_CYC[CNT_W-1:0] - 8'h01) begin
            count        <= 8'h00;
            state        <= ST_STROBE;
            readWriteN   <= !isWrite;
            dataPinOe    <= isWrite;
            outputDriveN <= isWrite;
          end
        end
        ST_STROBE: begin
          count <= count + 8'h01;
          // a low busy means the device gated this write; report it, do not retry
          if (!busySync && tokenSpaceSelectN) begin
            busySeen <= 1'b1;
          end
          if (count == STROBE_CYC[CNT_W-1:0] - 8'h01) begin
            count        <= 8'h00;
            state        <= ST_HOLD;
            readWriteN   <= 1'b1;
            outputDriveN <= 1'b1;
            // semaphore read is replicated on all bits; bit zero low means owned
            rspData      <= dataPinIn;
          end
        end
        ST_HOLD: begin
          count        <= count + 8'h01;
          dataPinOe    <= 1'b0;
          // dropping the selects reopens the token-space latch for a fresh read
          arraySelectN      <= 1'b1;
          tokenSpaceSelectN <= 1'b1;
          if (count == HOLD_CYC[CNT_W-1:0] - 8'h01) begin
            count <= 8'h00;
            if (op == `OP_SEM_TAKE && !verifyPhase) begin
              // write then read back, never the reverse, to avoid a contention gap
              verifyPhase       <= 1'b1;
              tokenSpaceSelectN <= 1'b0;
              state             <= ST_SETUP;
            end else begin
              state <= ST_VERIFY;
            end
          end
        end
        ST_VERIFY: begin
          rspValid <= 1'b1;
          rspBusy  <= busySeen;
          if (op == `OP_SEM_TAKE) begin
            // a failed take leaves the request pending; caller must re-read or free
            semOwned <= !rspData[0];
          end else if (op == `OP_SEM_FREE) begin
            semOwned <= 1'b0;
          end
          if (op == `OP_READ && addrPin == OWN_MAIL) begin
            mailboxPending <= 1'b0;
          end
          state <= ST_IDLE;
        end
        default: begin
          state <= ST_IDLE;
        end
      endcase
    end
  end
endmodule

/* test/dpram_port_ctrl_properties.sv */
// pin timing and handshake checks for the port controller
`timescale 1ns/1ps
module dpram_port_ctrl_properties (
  input wire        core_clk,
  input wire        rst,
  input wire        reqValid,
  input wire        reqReady,
  input wire [1:0]  reqOp,
  input wire        rspValid,
  input wire        rspBusy,
  input wire        semOwned,
  input wire        mailboxPending,
  input wire [14:0] addrPin,
  input wire        arraySelectN,
  input wire        tokenSpaceSelectN,
  input wire        readWriteN,
  input wire        dataPinOe,
  input wire        mailboxFlagPinN
);
  default clocking @(posedge core_clk); endclocking
  default disable iff (rst);
  AST_SETUP: assert property ($fell(readWriteN) |-> $stable(addrPin)) else $error("addr");
  AST_STROBE: assert property ($fell(readWriteN) |-> !readWriteN [*5] ##1 readWriteN)
    else $error("strobe width");
  AST_HOLD: assert property (!readWriteN |-> $stable(addrPin) && dataPinOe) else $error("hold");
  AST_SPACES: assert property (arraySelectN || tokenSpaceSelectN) else $error("both spaces");
  AST_IDLE: assert property (reqValid && reqReady |-> arraySelectN && tokenSpaceSelectN)
    else $error("not idle");
  AST_LAT: assert property (reqValid && reqReady && reqOp != 2'h2 |-> ##14 rspValid)
    else $error("latency");
  AST_TAKE: assert property (reqValid && reqReady && reqOp == 2'h2 |-> ##26 rspValid)
    else $error("take latency");
  AST_MAIL: assert property ($fell(mailboxFlagPinN) |-> ##[1:6] mailboxPending)
    else $error("mailbox");
  cover property (rspValid && rspBusy);
  cover property ($rose(semOwned));
  cover property ($rose(mailboxPending));
endmodule
bind dpram_port_ctrl dpram_port_ctrl_properties props_i (.*);

/* test/dpram_device_model.sv */
// device model seen from the left port; the far port is worked by the bench
`timescale 1ns/1ps
module dpram_device_model (
  input  wire [14:0] addrPin,
  input  wire        arraySelectN,
  input  wire        tokenSpaceSelectN,
  input  wire        readWriteN,
  input  wire        outputDriveN,
  input  wire [15:0] dataPinOut,
  output wire [15:0] dataPinIn,
  output wire        busyPinN,
  output reg         mailboxFlagPinN,
  input  wire        busyHold,
  input  wire        farMail,
  input  wire        farTake,
  input  wire        farFree
);
  reg [15:0] mem [0:32767];
  reg [1:0]  owner [0:7];
  reg [15:0] rdVal;
  reg        farReq;
  reg        farFlagN;
  integer    i;
  initial begin
    mailboxFlagPinN = 1'b1;
    farFlagN = 1'b1;
    farReq = 1'b0;
    rdVal = 16'h0000;
    for (i = 0; i < 8; i = i + 1) owner[i] = 2'h0;
  end
  // slave mode: the busy pin is only a write inhibit
  assign busyPinN = busyHold;
  // released bus shows the inverse so a stale read cannot pass
  assign dataPinIn = outputDriveN ? ~rdVal : rdVal;
  always @(posedge farMail) mailboxFlagPinN = 1'b0;
  always @* if (!arraySelectN && !outputDriveN && addrPin == 15'h7FFE) mailboxFlagPinN = 1'b1;
  always @(posedge farTake) begin
    farReq = 1'b1;
    if (owner[3] == 2'h0) owner[3] = 2'h2;
  end
  always @(posedge farFree) begin
    farReq = 1'b0;
    if (owner[3] == 2'h2) owner[3] = 2'h0;
  end
  always @(posedge readWriteN) begin
    if (!arraySelectN && busyPinN) mem[addrPin] = dataPinOut;
    if (!arraySelectN && busyPinN && addrPin == 15'h7FFF) farFlagN = 1'b0;
    if (!tokenSpaceSelectN && !dataPinOut[0] && owner[addrPin[2:0]] == 2'h0) owner[addrPin[2:0]] = 2'h1;
    if (!tokenSpaceSelectN && dataPinOut[0] && owner[addrPin[2:0]] == 2'h1)
      owner[addrPin[2:0]] = (farReq && addrPin[2:0] == 3'h3) ? 2'h2 : 2'h0;
  end
  always @(negedge outputDriveN)
    rdVal = tokenSpaceSelectN ? mem[addrPin] : {16{owner[addrPin[2:0]] != 2'h1}};
endmodule

/* test/testbench.sv */
// self-checking bench for the port controller against the device model
`timescale 1ns/1ps
module testbench;
  reg         core_clk, rst, reqValid, busyHold, farMail, farTake, farFree;
  reg  [1:0]  reqOp;
  reg  [14:0] reqAddr;
  reg  [15:0] reqData;
  wire        reqReady, rspValid, rspBusy, semOwned, mailboxPending, arraySelectN, dataPinOe;
  wire        tokenSpaceSelectN, readWriteN, outputDriveN, busyPinN, mailboxFlagPinN;
  wire [15:0] rspData, dataPinOut, dataPinIn;
  wire [14:0] addrPin;
  integer     errors, checks, n;
  dpram_port_ctrl dpram_port_ctrl_i (.*);
  dpram_device_model dpram_device_model_i (.*);
  initial begin
    core_clk = 1'b0;
    forever #4 core_clk = ~core_clk;
  end
  task chk(input [15:0] seen, input [15:0] exp);
    checks = checks + 1;
    if (seen !== exp) begin
      errors = errors + 1;
      $display("ERROR %0t seen %h expected %h", $time, seen, exp);
    end
  endtask
  task close_out;
    if (errors == 0 && checks > 0) $display("Result: passed");
    else $display("Result: failed");
    $finish;
  endtask
  // request held until taken, then a bounded wait for the answer
  task req(input [1:0] op, input [14:0] a, input [15:0] d);
    reqValid <= 1'b1;
    reqOp <= op;
    reqAddr <= a;
    reqData <= d;
    n = 0;
    @(posedge core_clk);
    while (reqReady !== 1'b1 && n < 50) begin @(posedge core_clk); n = n + 1; end
    reqValid <= 1'b0;
    while (rspValid !== 1'b1 && n < 100) begin @(posedge core_clk); n = n + 1; end
    if (rspValid !== 1'b1) begin errors = errors + 1; close_out; end
  endtask
  task t_mem;
    req(2'h1, 15'h7FFF, 16'hBEEF);
    chk(dpram_device_model_i.farFlagN, 1'b0);
    req(2'h1, 15'h0005, 16'h1234);
    req(2'h0, 15'h7FFF, 16'h0000);
    chk(rspData, 16'hBEEF);
    req(2'h0, 15'h0005, 16'h0000);
    chk(rspData, 16'h1234);
  endtask
  task t_busy;
    busyHold <= 1'b0;
    req(2'h1, 15'h0005, 16'h5555);
    chk(rspBusy, 1'b1);
    busyHold <= 1'b1;
    req(2'h0, 15'h0005, 16'h0000);
    chk(rspData, 16'h1234);
    chk(rspBusy, 1'b0);
  endtask
  task t_mail;
    farMail <= 1'b1;
    repeat (8) @(posedge core_clk);
    chk(mailboxPending, 1'b1);
    req(2'h0, 15'h7FFE, 16'h0000);
    repeat (8) @(posedge core_clk);
    chk(mailboxPending, 1'b0);
  endtask
  task t_sem;
    req(2'h2, 15'h0003, 16'h0000);
    chk(semOwned, 1'b1);
    chk(rspData, 16'h0000);
    farTake <= 1'b1;
    req(2'h3, 15'h7FF3, 16'h0000);
    chk(semOwned, 1'b0);
    req(2'h2, 15'h000B, 16'h0000);
    chk(semOwned, 1'b0);
    chk(rspData, 16'hFFFF);
    req(2'h3, 15'h0003, 16'h0000);
    farFree <= 1'b1;
    req(2'h2, 15'h0003, 16'h0000);
    chk(semOwned, 1'b1);
  endtask
  initial begin
    {rst, busyHold} = 2'h3;
    {reqValid, farMail, farTake, farFree, reqOp, reqAddr, reqData} = 0;
    errors = 0;
    checks = 0;
    repeat (16) @(posedge core_clk);
    rst <= 1'b0;
    t_mem;
    t_busy;
    t_mail;
    t_sem;
    close_out;
  end
endmodule
